// ==== core/prt_timer.sv ====
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module prt_timer (
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic onchip_osc_clock,
    input wire logic subclock_div32,
    input wire logic subclock_source,
    output logic timer_irq,
    output logic [1:0] pin_route,
    output logic count_source_active
);
    logic [7:0] io_reg, mode_reg, route_reg;
    logic run_reg, active_reg, edge_reg, undf_reg;
    logic [7:0] pre_reload_reg, pre_count_reg, main_reload_reg, main_count_reg;
    logic [2:0] div_reg;
    logic [2:0] osc_sync_reg, c32_sync_reg, csub_sync_reg;
    logic tick, pre_under, main_under, src_level;
    logic wr, rd_ok;
    logic [11:0] idx;
    prt_pkg::prt_pin_t pin_cfg;

    // apb decode: zero-wait, word index from byte address
    assign idx = paddr[13:2];
    assign wr = psel && penable && pwrite;
    assign rd_ok = (idx == prt_pkg::CONTROL_IDX) || (idx == prt_pkg::IO_CONTROL_IDX)
        || (idx == prt_pkg::MODE_SELECT_IDX) || (idx == prt_pkg::PRESCALE_IDX)
        || (idx == prt_pkg::MAIN_COUNT_IDX) || (idx == prt_pkg::PIN_ROUTING_IDX);

    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        hit = (a == r);
    endfunction

    // pin inputs pass two flops, third for edge detect
    always_ff @(posedge clock) begin
        if (reset) begin
            osc_sync_reg <= 3'h0;
            c32_sync_reg <= 3'h0;
            csub_sync_reg <= 3'h0;
        end else begin
            osc_sync_reg <= {osc_sync_reg[1:0], onchip_osc_clock};
            c32_sync_reg <= {c32_sync_reg[1:0], subclock_div32};
            csub_sync_reg <= {csub_sync_reg[1:0], subclock_source};
        end
    end

    // system clock divider for f2 and f8 enables
    always_ff @(posedge clock) begin
        if (reset) begin
            div_reg <= 3'h0;
        end else begin
            div_reg <= div_reg + 3'h1;
        end
    end

    // count source select and cutoff
    always_comb begin
        unique case (mode_reg[6:4])
            prt_pkg::SRC_DIV1: src_level = 1'b1;
            prt_pkg::SRC_DIV8: src_level = (div_reg == prt_pkg::DIV_LAST);
            prt_pkg::SRC_OSC: src_level = osc_sync_reg[1] && !osc_sync_reg[2];
            prt_pkg::SRC_DIV2: src_level = div_reg[0];
            prt_pkg::SRC_SUB32: src_level = c32_sync_reg[1] && !c32_sync_reg[2];
            prt_pkg::SRC_SUB: src_level = csub_sync_reg[1] && !csub_sync_reg[2];
            default: src_level = 1'b0;
        endcase
    end
    assign tick = src_level && !mode_reg[7] && active_reg;
    assign pre_under = tick && (pre_count_reg == prt_pkg::ZERO8);
    assign main_under = pre_under && (main_count_reg == prt_pkg::ZERO8);

    // route field carried to the output stage as the pin struct
    assign pin_cfg.route = route_reg[1:0];

    // control: start, status, forced halt, flags
    always_ff @(posedge clock) begin
        if (reset) begin
            run_reg <= 1'b0;
            active_reg <= 1'b0;
            edge_reg <= 1'b0;
            undf_reg <= 1'b0;
        end else begin
            active_reg <= run_reg;
            if (wr && hit(idx, prt_pkg::CONTROL_IDX)) begin
                if (pwdata[prt_pkg::HALT_BIT]) begin
                    run_reg <= 1'b0;
                    active_reg <= 1'b0;
                end else begin
                    run_reg <= pwdata[prt_pkg::RUN_BIT];
                end
                if (!pwdata[prt_pkg::EDGE_BIT]) edge_reg <= 1'b0;
                if (!pwdata[prt_pkg::UNDF_BIT]) undf_reg <= 1'b0;
            end
            if (main_under) undf_reg <= 1'b1; // set wins over clear
        end
    end

    // config registers; unassigned bits masked
    always_ff @(posedge clock) begin
        if (reset) begin
            io_reg <= prt_pkg::ZERO8;
            mode_reg <= prt_pkg::ZERO8;
            route_reg <= prt_pkg::ZERO8;
        end else if (wr) begin
            if (hit(idx, prt_pkg::IO_CONTROL_IDX)) io_reg <= pwdata[7:0];
            if (hit(idx, prt_pkg::MODE_SELECT_IDX)) mode_reg <= pwdata[7:0] & prt_pkg::MODE_WMASK;
            if (hit(idx, prt_pkg::PIN_ROUTING_IDX)) route_reg <= pwdata[7:0] & prt_pkg::ROUTE_WMASK;
        end
    end

    // prescaler stage
    always_ff @(posedge clock) begin
        if (reset) begin
            pre_reload_reg <= prt_pkg::COUNT_RESET;
            pre_count_reg <= prt_pkg::COUNT_RESET;
        end else if (wr && hit(idx, prt_pkg::CONTROL_IDX) && pwdata[prt_pkg::HALT_BIT]) begin
            pre_reload_reg <= prt_pkg::COUNT_RESET;
            pre_count_reg <= prt_pkg::COUNT_RESET;
        end else begin
            if (wr && hit(idx, prt_pkg::PRESCALE_IDX)) begin
                pre_reload_reg <= pwdata[7:0];
                if (!active_reg) pre_count_reg <= pwdata[7:0];
            end
            if (tick) begin
                if (pre_under) pre_count_reg <= pre_reload_reg;
                else pre_count_reg <= pre_count_reg - 8'h01;
            end
        end
    end

    // main timer stage, steps on prescaler underflow
    always_ff @(posedge clock) begin
        if (reset) begin
            main_reload_reg <= prt_pkg::COUNT_RESET;
            main_count_reg <= prt_pkg::COUNT_RESET;
        end else if (wr && hit(idx, prt_pkg::CONTROL_IDX) && pwdata[prt_pkg::HALT_BIT]) begin
            main_reload_reg <= prt_pkg::COUNT_RESET;
            main_count_reg <= prt_pkg::COUNT_RESET;
        end else begin
            if (wr && hit(idx, prt_pkg::MAIN_COUNT_IDX)) begin
                main_reload_reg <= pwdata[7:0];
                if (!active_reg) main_count_reg <= pwdata[7:0];
            end
            if (pre_under) begin
                if (main_under) main_count_reg <= main_reload_reg;
                else main_count_reg <= main_count_reg - 8'h01;
            end
        end
    end

    // outputs: irq pulse, pin route, activity
    always_ff @(posedge clock) begin
        if (reset) begin
            timer_irq <= 1'b0;
            pin_route <= 2'h0;
            count_source_active <= 1'b0;
        end else begin
            timer_irq <= main_under;
            pin_route <= pin_cfg.route;
            count_source_active <= active_reg && !mode_reg[7];
        end
    end

    // apb read data, counters not reload values
    always_ff @(posedge clock) begin
        if (reset) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !rd_ok;
            prdata <= 32'h0;
            if (psel && !penable && !pwrite) begin
                if (hit(idx, prt_pkg::CONTROL_IDX))
                    prdata[7:0] <= {2'b00, undf_reg, edge_reg, 2'b00, active_reg, run_reg};
                if (hit(idx, prt_pkg::IO_CONTROL_IDX)) prdata[7:0] <= io_reg;
                if (hit(idx, prt_pkg::MODE_SELECT_IDX)) prdata[7:0] <= mode_reg;
                if (hit(idx, prt_pkg::PRESCALE_IDX)) prdata[7:0] <= pre_count_reg;
                if (hit(idx, prt_pkg::MAIN_COUNT_IDX)) prdata[7:0] <= main_count_reg;
                if (hit(idx, prt_pkg::PIN_ROUTING_IDX)) prdata[7:0] <= route_reg;
            end
        end
    end

    // forced halt: the write, then both stages back at their reset counts
    sequence s_halt_write;
        wr && hit(idx, prt_pkg::CONTROL_IDX) && pwdata[prt_pkg::HALT_BIT];
    endsequence

    sequence s_counts_reset;
        pre_count_reg == prt_pkg::COUNT_RESET && main_count_reg == prt_pkg::COUNT_RESET;
    endsequence

    sequence s_run_cleared;
        !run_reg && !active_reg;
    endsequence

    a_halt_counts: assert property (@(posedge clock) disable iff (reset)
        s_halt_write |=> s_counts_reset ##0 s_run_cleared)
        else $error("forced halt did not reset counts");
    a_run_status: assert property (@(posedge clock) disable iff (reset)
        $rose(run_reg) |=> active_reg)
        else $error("status flag did not follow start");
    a_start_write: assert property (@(posedge clock) disable iff (reset)
        wr && hit(idx, prt_pkg::CONTROL_IDX) && !pwdata[prt_pkg::HALT_BIT] |=> run_reg == $past(pwdata[0]))
        else $error("start bit write lost");
    a_irq_under: assert property (@(posedge clock) disable iff (reset)
        main_under |=> timer_irq)
        else $error("no interrupt on underflow");
    a_reload_main: assert property (@(posedge clock) disable iff (reset)
        main_under && !wr |=> main_count_reg == $past(main_reload_reg))
        else $error("main did not reload");
    a_pre_dec: assert property (@(posedge clock) disable iff (reset)
        tick && !pre_under && !wr |=> pre_count_reg == $past(pre_count_reg) - 8'h01)
        else $error("prescaler did not decrement");
    a_cutoff_block: assert property (@(posedge clock) disable iff (reset)
        mode_reg[7] && !wr |=> $stable(pre_count_reg))
        else $error("count moved with source cut off");
    a_flag_keep: assert property (@(posedge clock) disable iff (reset)
        wr && hit(idx, prt_pkg::CONTROL_IDX) && pwdata[5] && undf_reg |=> undf_reg)
        else $error("write 1 changed underflow flag");
    a_mode_mask: assert property (@(posedge clock) disable iff (reset)
        !mode_reg[3] && !route_reg[7])
        else $error("unassigned bit set");

    // stopped writes land in the counter at once
    a_stopped_pre: assert property (@(posedge clock) disable iff (reset)
        wr && hit(idx, prt_pkg::PRESCALE_IDX) && !active_reg |=> pre_count_reg == $past(pwdata[7:0]))
        else $error("stopped prescaler write not loaded");

    // same for the main stage
    a_stopped_main: assert property (@(posedge clock) disable iff (reset)
        wr && hit(idx, prt_pkg::MAIN_COUNT_IDX) && !active_reg |=> main_count_reg == $past(pwdata[7:0]))
        else $error("stopped main write not loaded");

    // running write without a tick leaves the counter alone
    a_running_hold: assert property (@(posedge clock) disable iff (reset)
        wr && hit(idx, prt_pkg::PRESCALE_IDX) && active_reg && !tick |=> $stable(pre_count_reg))
        else $error("running write reached counter early");

    // every prescaler write reaches its reload register
    a_reload_take: assert property (@(posedge clock) disable iff (reset)
        wr && hit(idx, prt_pkg::PRESCALE_IDX) |=> pre_reload_reg == $past(pwdata[7:0]))
        else $error("prescaler reload not written");

    // main counter steps once per prescaler underflow
    a_main_step: assert property (@(posedge clock) disable iff (reset)
        pre_under && !main_under && !wr |=> main_count_reg == $past(main_count_reg) - 8'h01)
        else $error("main did not decrement");

    // main counter holds between prescaler underflows
    a_main_hold: assert property (@(posedge clock) disable iff (reset)
        !pre_under && !wr |=> $stable(main_count_reg))
        else $error("main moved without prescaler underflow");

    // prescaler reloads past zero
    a_pre_reload: assert property (@(posedge clock) disable iff (reset)
        pre_under && !wr |=> pre_count_reg == $past(pre_reload_reg))
        else $error("prescaler did not reload");

    // interrupt only follows an underflow
    a_irq_only: assert property (@(posedge clock) disable iff (reset)
        timer_irq |-> $past(main_under))
        else $error("interrupt without underflow");

    // reads of the main address give the live count
    a_read_count: assert property (@(posedge clock) disable iff (reset)
        psel && !penable && !pwrite && hit(idx, prt_pkg::MAIN_COUNT_IDX)
        |=> prdata[7:0] == $past(main_count_reg))
        else $error("main read not the counter");

    // halt bit always reads zero
    a_halt_reads0: assert property (@(posedge clock) disable iff (reset)
        psel && !penable && !pwrite && hit(idx, prt_pkg::CONTROL_IDX) |=> !prdata[prt_pkg::HALT_BIT])
        else $error("halt bit read as one");

    // status drops once start is clear
    a_active_follow: assert property (@(posedge clock) disable iff (reset)
        !run_reg |=> !active_reg)
        else $error("status flag outlived start");

    // reserved source codes give no ticks
    a_src_reserved: assert property (@(posedge clock) disable iff (reset)
        mode_reg[6:4] inside {3'h5, 3'h7} |-> !tick)
        else $error("tick from reserved source");

    // pin route output copies the register
    a_route_copy: assert property (@(posedge clock) disable iff (reset)
        1'b1 |=> pin_route == $past(route_reg[1:0]))
        else $error("pin route not copied");

    // io control register takes the whole byte
    a_io_write: assert property (@(posedge clock) disable iff (reset)
        wr && hit(idx, prt_pkg::IO_CONTROL_IDX) |=> io_reg == $past(pwdata[7:0]))
        else $error("io control write lost");

    // bus answer comes one cycle after setup
    a_ready_once: assert property (@(posedge clock) disable iff (reset)
        psel && !penable |=> pready)
        else $error("no ready after setup");

    // error only travels with ready
    a_err_pair: assert property (@(posedge clock) disable iff (reset)
        pslverr |-> pready)
        else $error("error without ready");

    // upper read bits stay zero, 8-bit registers
    a_upper_zero: assert property (@(posedge clock) disable iff (reset)
        prdata[31:8] == 24'h000000)
        else $error("upper read bits set");
endmodule

// ==== core/prt_pkg.sv ====
package prt_pkg;
    // register word indices (printed offsets are not all multiples of four: index times four)
    localparam logic [11:0] CONTROL_IDX = 12'h100;
    localparam logic [11:0] IO_CONTROL_IDX = 12'h101;
    localparam logic [11:0] MODE_SELECT_IDX = 12'h102;
    localparam logic [11:0] PRESCALE_IDX = 12'h103;
    localparam logic [11:0] MAIN_COUNT_IDX = 12'h104;
    localparam logic [11:0] PIN_ROUTING_IDX = 12'h180;
    localparam int ADDR_W = 14;
    // control field positions
    localparam int RUN_BIT = 0;
    localparam int ACTIVE_BIT = 1;
    localparam int HALT_BIT = 2;
    localparam int EDGE_BIT = 4;
    localparam int UNDF_BIT = 5;
    localparam logic [7:0] MODE_WMASK = 8'hF7;
    localparam logic [7:0] ROUTE_WMASK = 8'h1F;
    localparam logic [7:0] COUNT_RESET = 8'hFF;
    localparam logic [7:0] ZERO8 = 8'h00;
    // count source selections
    localparam logic [2:0] SRC_DIV1 = 3'h0;
    localparam logic [2:0] SRC_DIV8 = 3'h1;
    localparam logic [2:0] SRC_OSC = 3'h2;
    localparam logic [2:0] SRC_DIV2 = 3'h3;
    localparam logic [2:0] SRC_SUB32 = 3'h4;
    localparam logic [2:0] SRC_SUB = 3'h6;
    localparam logic [2:0] DIV_LAST = 3'h7;
    typedef enum logic [2:0] {
        PRT_TIMER = 3'h0,
        PRT_PULSE_OUT = 3'h1,
        PRT_EVENT = 3'h2,
        PRT_WIDTH = 3'h3,
        PRT_PERIOD = 3'h4
    } prt_mode_t;
    typedef struct packed {
        logic [1:0] route;
    } prt_pin_t;
endpackage

// ==== dv/prt_timer_test.sv ====
`timescale 1ns/1ps
module prt_timer_test;
    logic clock, reset, psel, penable, pwrite, err;
    logic osc = 1'b0;
    logic sub32 = 1'b0;
    logic sub = 1'b0;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, timer_irq, count_source_active;
    logic [1:0] pin_route;
    logic [5:0] tk = 6'h00;
    int errors = 0;
    int n_tests = 0;
    int gap;

    prt_timer uut (.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .onchip_osc_clock(osc), .subclock_div32(sub32), .subclock_source(sub),
        .timer_irq(timer_irq), .pin_route(pin_route), .count_source_active(count_source_active));

    // free-running system clock
    initial begin
        clock = 0;
        forever #20 clock = ~clock;
    end

    // slow square waves on the asynchronous source inputs, oscillator period 8 cycles
    always @(posedge clock) begin
        tk <= tk + 6'h01;
        osc <= tk[2];
        sub <= tk[4];
        sub32 <= tk[5];
    end

    // compare and count
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task apb(input logic wr, input logic [11:0] idx, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wt(input logic [11:0] idx, input logic [7:0] d);
        apb(1'b1, idx, {24'h000000, d});
    endtask

    task rdchk(input string name, input logic [11:0] idx, input logic [31:0] mask, input logic [31:0] exp);
        apb(1'b0, idx, 32'h00000000);
        chk(name, rd & mask, exp);
    endtask

    // wait for an interrupt pulse; gap is the cycle index, or lim if none came
    task wirq(input int lim);
        gap = lim;
        for (int i = 0; i < lim; i++) begin
            @(posedge clock);
            if (timer_irq === 1'b1) begin
                gap = i;
                break;
            end
        end
    endtask

    task t_reset;
        rdchk("control", prt_pkg::CONTROL_IDX, 32'hFFFFFFFF, 32'h00000000);
        rdchk("io", prt_pkg::IO_CONTROL_IDX, 32'hFFFFFFFF, 32'h00000000);
        rdchk("mode", prt_pkg::MODE_SELECT_IDX, 32'hFFFFFFFF, 32'h00000000);
        rdchk("prescale", prt_pkg::PRESCALE_IDX, 32'hFFFFFFFF, 32'h000000FF);
        rdchk("main", prt_pkg::MAIN_COUNT_IDX, 32'hFFFFFFFF, 32'h000000FF);
        rdchk("route", prt_pkg::PIN_ROUTING_IDX, 32'hFFFFFFFF, 32'h00000000);
        apb(1'b0, 12'h7FF, 32'h00000000);
        chk("unmapped", {31'h0, err}, 32'h00000001);
    endtask

    task t_regs;
        for (int r = 2; r >= 0; r--) begin
            wt(prt_pkg::PIN_ROUTING_IDX, 8'(r));
            repeat (2) @(posedge clock);
            chk("pin route", {30'h0, pin_route}, 32'(r));
        end
        wt(prt_pkg::IO_CONTROL_IDX, 8'hA5);
        rdchk("io", prt_pkg::IO_CONTROL_IDX, 32'hFFFFFFFF, 32'h000000A5);
        for (int m = 0; m < 5; m++) begin
            wt(prt_pkg::MODE_SELECT_IDX, 8'(m));
            rdchk("mode code", prt_pkg::MODE_SELECT_IDX, 32'hFFFFFFFF, 32'(m));
        end
        wt(prt_pkg::MODE_SELECT_IDX, 8'h88);
        rdchk("mode mask", prt_pkg::MODE_SELECT_IDX, 32'hFFFFFFFF, 32'h00000080);
        wt(prt_pkg::CONTROL_IDX, 8'hC8);
        rdchk("control mask", prt_pkg::CONTROL_IDX, 32'hFFFFFFFF, 32'h00000000);
    endtask

    task t_period;
        wt(prt_pkg::PRESCALE_IDX, 8'h01);
        wt(prt_pkg::MAIN_COUNT_IDX, 8'h02);
        rdchk("prescale", prt_pkg::PRESCALE_IDX, 32'hFFFFFFFF, 32'h00000001);
        rdchk("main", prt_pkg::MAIN_COUNT_IDX, 32'hFFFFFFFF, 32'h00000002);
        wt(prt_pkg::MODE_SELECT_IDX, 8'h00);
        wt(prt_pkg::CONTROL_IDX, 8'h01);
        rdchk("running", prt_pkg::CONTROL_IDX, 32'h00000007, 32'h00000003);
        wirq(40);
        wirq(40);
        chk("period", 32'(gap + 1), 32'd6);
        wt(prt_pkg::MAIN_COUNT_IDX, 8'h00);
        wirq(40);
        wirq(40);
        wirq(40);
        chk("reload period", 32'(gap + 1), 32'd2);
        wt(prt_pkg::CONTROL_IDX, 8'h20);
        rdchk("flag kept", prt_pkg::CONTROL_IDX, 32'hFFFFFFFF, 32'h00000020);
        wt(prt_pkg::MODE_SELECT_IDX, 8'h03);
        wt(prt_pkg::CONTROL_IDX, 8'h30);
        rdchk("flag whole write", prt_pkg::CONTROL_IDX, 32'hFFFFFFFF, 32'h00000020);
        wt(prt_pkg::MODE_SELECT_IDX, 8'h00);
        wt(prt_pkg::CONTROL_IDX, 8'h00);
        rdchk("flag clear", prt_pkg::CONTROL_IDX, 32'hFFFFFFFF, 32'h00000000);
    endtask

    task t_cutoff_halt;
        wt(prt_pkg::PRESCALE_IDX, 8'h00);
        wt(prt_pkg::MODE_SELECT_IDX, 8'h80);
        wt(prt_pkg::CONTROL_IDX, 8'h01);
        wirq(30);
        chk("cut irq", 32'(gap), 32'd30);
        chk("cut active", {31'h0, count_source_active}, 32'h00000000);
        wt(prt_pkg::CONTROL_IDX, 8'h00);
        wt(prt_pkg::MODE_SELECT_IDX, 8'h00);
        wt(prt_pkg::CONTROL_IDX, 8'h01);
        wirq(10);
        chk("pass irq", {31'h0, gap < 10}, 32'h00000001);
        chk("pass active", {31'h0, count_source_active}, 32'h00000001);
        wt(prt_pkg::CONTROL_IDX, 8'h05);
        rdchk("halt ctl", prt_pkg::CONTROL_IDX, 32'h00000007, 32'h00000000);
        rdchk("halt pre", prt_pkg::PRESCALE_IDX, 32'hFFFFFFFF, 32'h000000FF);
        rdchk("halt main", prt_pkg::MAIN_COUNT_IDX, 32'hFFFFFFFF, 32'h000000FF);
    endtask

    // one count source: n=0, m=1, so the period is two source ticks
    task t_src(input logic [2:0] code, input int per);
        wt(prt_pkg::PRESCALE_IDX, 8'h00);
        wt(prt_pkg::MAIN_COUNT_IDX, 8'h01);
        wt(prt_pkg::MODE_SELECT_IDX, {1'b0, code, 4'h0});
        wt(prt_pkg::CONTROL_IDX, 8'h01);
        wirq(300);
        wirq(300);
        chk("source period", 32'(gap + 1), 32'(per));
        wt(prt_pkg::CONTROL_IDX, 8'h04);
    endtask

    // verdict and end of run
    task complete_run;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // watchdog cuts a hang short
    initial begin
        #2000000;
        errors++;
        complete_run;
    end

    // reset, then the scenarios in turn
    initial begin
        {reset, psel, penable, pwrite} = 4'b1000;
        paddr = 14'h0000;
        pwdata = 32'h00000000;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        t_reset;
        t_regs;
        t_period;
        t_cutoff_halt;
        t_src(prt_pkg::SRC_DIV1, 2);
        t_src(prt_pkg::SRC_DIV2, 4);
        t_src(prt_pkg::SRC_DIV8, 16);
        t_src(prt_pkg::SRC_OSC, 16);
        t_src(prt_pkg::SRC_SUB, 64);
        t_src(prt_pkg::SRC_SUB32, 128);
        complete_run;
    end
endmodule
